// ---- core/ipm_pkg.sv ----
// Constants, types and mode decode for the IMU power-mode control block
package ipm_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned BOOT_TIME_MS = 10;
	// Longest time, so rounding down is safe
	localparam int unsigned BOOT_CYC = BOOT_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned BASE_RATE_HZ = 6667;
	localparam int unsigned BASE_CYC = CLK_HZ / BASE_RATE_HZ;
	localparam int unsigned BASE_CNT_W = 12;
	localparam int unsigned DIV_W = 12;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_ACCEL_RATE_CTRL = 8'h10;
	localparam logic [7:0] ADDR_GYRO_RATE_CTRL = 8'h11;
	localparam logic [7:0] ADDR_CONTROL_FOUR_REG = 8'h13;
	localparam logic [7:0] ADDR_MODE_CTRL_C = 8'h15;
	localparam logic [7:0] ADDR_GYRO_MODE_CTRL = 8'h16;
	localparam logic [7:0] ADDR_DATA_READY_STATUS = 8'h1e;
	localparam logic [7:0] ADDR_ACCEL_Z_OUT_LOW = 8'h2c;
	localparam logic [7:0] ADDR_ACCEL_Z_OUT_HIGH = 8'h2d;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int unsigned RATE_SEL_LSB = 4;
	localparam int unsigned ACCEL_HP_DIS_BIT = 4;
	localparam int unsigned GYRO_HP_DIS_BIT = 7;
	localparam int unsigned GYRO_SLEEP_BIT = 6;
	localparam int unsigned ACCEL_DRDY_BIT = 0;
	localparam int unsigned GYRO_DRDY_BIT = 1;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ------------------------------------------------------------
	// Rate codes
	// ------------------------------------------------------------
	localparam logic [3:0] RATE_PD = 4'h0;
	localparam logic [3:0] RATE_LP_LAST = 4'h5;
	localparam logic [3:0] RATE_HP_LAST = 4'ha;
	localparam logic [3:0] RATE_ACC_1HZ6 = 4'hb;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		PM_DOWN = 4'b0001,
		PM_LOW = 4'b0010,
		PM_HIGH = 4'b0100,
		PM_SLEEP = 4'b1000
	} ipm_mode_t;

	typedef enum logic [1:0] {
		BT_BOOT = 2'b01,
		BT_RUN = 2'b10
	} ipm_boot_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ipm_reg_req_t;

	// Codes 0001..0101 obey hp_dis; 0110..1010 always high-performance
	function automatic ipm_mode_t mode_of(input logic [3:0] code,
		input logic hp_dis, input logic is_acc);
		ipm_mode_t m;
		m = PM_DOWN;
		if (code != RATE_PD && code <= RATE_LP_LAST) begin
			m = hp_dis ? PM_LOW : PM_HIGH;
		end else if (code > RATE_LP_LAST && code <= RATE_HP_LAST) begin
			m = PM_HIGH;
		end else if (is_acc && code == RATE_ACC_1HZ6 && hp_dis) begin
			m = PM_LOW;
		end
		return m;
	endfunction : mode_of

	// Divide-by-power-of-two of the base rate for each code
	function automatic logic [3:0] shift_of(input logic [3:0] code);
		logic [3:0] s;
		s = 4'hc;
		if (code != RATE_PD && code <= RATE_HP_LAST) begin
			s = RATE_HP_LAST - code;
		end
		return s;
	endfunction : shift_of

endpackage : ipm_pkg

// ---- core/ipm_rate_gen.sv ----
// Shared sample-rate timebase producing per-sensor sample ticks
`timescale 1ns/1ps
`default_nettype none
module ipm_rate_gen
	import ipm_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [3:0] acc_code_i,
	input wire logic [3:0] gyr_code_i,
	input wire logic acc_en_i,
	input wire logic gyr_en_i,
	output logic acc_tick_o,
	output logic gyr_tick_o
);

	// ------------------------------------------------------------
	// Base divider
	// ------------------------------------------------------------
	logic [DIV_W-1:0] div_r;
	logic [BASE_CNT_W-1:0] base_cnt_r;
	logic [1:0] tick_r;
	wire logic base_stb = (div_r == DIV_W'(BASE_CYC - 1));
	wire logic [3:0] code [2];
	wire logic en [2];

	assign code[0] = acc_code_i;
	assign code[1] = gyr_code_i;
	assign en[0] = acc_en_i;
	assign en[1] = gyr_en_i;

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			div_r <= '0;
			base_cnt_r <= '0;
		end else begin
			div_r <= base_stb ? '0 : div_r + 1'b1;
			if (base_stb) begin
				base_cnt_r <= base_cnt_r + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Per-sensor ticks
	// ------------------------------------------------------------
	// R7: common counter, rates nest
	// One counter feeds both, so ticks of the slower sensor always
	// coincide with ticks of the faster one.
	for (genvar i = 0; i < 2; i++) begin : g_ch
		wire logic [BASE_CNT_W-1:0] mask =
			BASE_CNT_W'((13'h1 << shift_of(code[i])) - 13'h1);
		wire logic hit = base_stb && en[i] && ((base_cnt_r & mask) == '0);
		always_ff @(posedge clk_sys_i or posedge reset_i) begin
			if (reset_i) begin
				tick_r[i] <= 1'b0;
			end else begin
				tick_r[i] <= hit;
			end
		end
	end

	assign acc_tick_o = tick_r[0];
	assign gyr_tick_o = tick_r[1];

endmodule : ipm_rate_gen
`default_nettype wire

// ---- core/ipm_power_ctrl.sv ----
// IMU power-mode, rate selection and data-ready control
// Contract
// R1: Boot loads trimming, at most 10 ms
// R2: After boot both sensors power down
// R3: Sensors configured independently, three power modes
// R4: Any combination of the two rates allowed
// R5: Accel-only, gyro-only or both active supported
// R6: Gyro sleep state saves power
// R7: Both running: accel synchronised to gyro
// R8: Accel rate and hp_disable select accel mode
// R9: Accel code table for power modes
// R10: Accel 1011 is 1.6 Hz low-power only
// R11: Gyro rate and hp_disable select gyro mode
// R12: Gyro code table for power modes
// R13: Host disables hp, writes 50h, reads 2Dh
// R14: Host waits one sample, re-enables, writes rate
// R15: Reading accel Z high clears accel ready
// R16: Power-down keeps config, holds output data
// R17: Sleep bit puts running gyro to sleep
// R18: High-performance: always on, data and ready
`timescale 1ns/1ps
`default_nettype none
module ipm_power_ctrl
	import ipm_pkg::*;
#(
	parameter int unsigned BOOT_CYCLES = BOOT_CYC
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire ipm_reg_req_t reg_req_i,
	input wire logic [15:0] accel_z_sample_i,
	output logic [7:0] reg_rdata_o,
	output logic boot_busy_o,
	output logic trim_load_o,
	output ipm_mode_t accel_mode_o,
	output ipm_mode_t gyro_mode_o,
	output logic accel_on_o,
	output logic gyro_drive_on_o,
	output logic accel_sample_o,
	output logic gyro_sample_o,
	output logic accel_drdy_o,
	output logic gyro_drdy_o
);

	// ------------------------------------------------------------
	// Boot sequencer
	// ------------------------------------------------------------
	ipm_boot_t boot_r;
	ipm_boot_t boot_nxt;
	logic [17:0] boot_cnt_r;
	wire logic boot_end = (boot_cnt_r == 18'(BOOT_CYCLES - 1));

	// R1: bounded boot count
	always_comb begin
		case (boot_r)
			BT_BOOT: boot_nxt = boot_end ? BT_RUN : BT_BOOT;
			BT_RUN: boot_nxt = BT_RUN;
			default: boot_nxt = BT_BOOT;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			boot_r <= BT_BOOT;
			boot_cnt_r <= '0;
		end else begin
			boot_r <= boot_nxt;
			if (boot_r == BT_BOOT) begin
				boot_cnt_r <= boot_cnt_r + 1'b1;
			end
		end
	end

	wire logic running = (boot_r == BT_RUN);

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	// Accesses during boot are ignored; the interface stays quiet
	wire logic wr_ok = reg_req_i.wr && running;
	wire logic rd_ok = reg_req_i.rd && running;
	wire logic wr_acc_rate = wr_ok && reg_req_i.addr == ADDR_ACCEL_RATE_CTRL;
	wire logic wr_gyr_rate = wr_ok && reg_req_i.addr == ADDR_GYRO_RATE_CTRL;
	wire logic wr_ctrl4 = wr_ok && reg_req_i.addr == ADDR_CONTROL_FOUR_REG;
	wire logic wr_ctrl6 = wr_ok && reg_req_i.addr == ADDR_MODE_CTRL_C;
	wire logic wr_ctrl7 = wr_ok && reg_req_i.addr == ADDR_GYRO_MODE_CTRL;
	wire logic rd_z_high = rd_ok && reg_req_i.addr == ADDR_ACCEL_Z_OUT_HIGH;
	wire logic rd_status = rd_ok && reg_req_i.addr == ADDR_DATA_READY_STATUS;

	logic [7:0] acc_rate_r;
	logic [7:0] gyr_rate_r;
	logic [7:0] ctrl4_r;
	logic [7:0] ctrl6_r;
	logic [7:0] ctrl7_r;
	logic [15:0] acc_z_r;
	logic acc_drdy_r;
	logic gyr_drdy_r;

	// R2: reset values mean power-down
	// R3: separate registers per sensor
	// R16: config kept in every mode
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			acc_rate_r <= CTRL_RESET;
			gyr_rate_r <= CTRL_RESET;
			ctrl4_r <= CTRL_RESET;
			ctrl6_r <= CTRL_RESET;
			ctrl7_r <= CTRL_RESET;
		end else begin
			if (wr_acc_rate) acc_rate_r <= reg_req_i.wdata;
			if (wr_gyr_rate) gyr_rate_r <= reg_req_i.wdata;
			if (wr_ctrl4) ctrl4_r <= reg_req_i.wdata;
			if (wr_ctrl6) ctrl6_r <= reg_req_i.wdata;
			if (wr_ctrl7) ctrl7_r <= reg_req_i.wdata;
		end
	end

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	wire logic [3:0] acc_code = acc_rate_r[RATE_SEL_LSB +: 4];
	wire logic [3:0] gyr_code = gyr_rate_r[RATE_SEL_LSB +: 4];
	// R8: accel rate with hp disable
	// R9: accel table decode
	// R10: 1011 only with hp disabled
	wire ipm_mode_t acc_mode =
		mode_of(acc_code, ctrl6_r[ACCEL_HP_DIS_BIT], 1'b1);
	// R11: gyro rate with hp disable
	// R12: gyro table decode
	wire ipm_mode_t gyr_run_mode =
		mode_of(gyr_code, ctrl7_r[GYRO_HP_DIS_BIT], 1'b0);
	// R6: sleep state for gyro
	// R17: sleep overrides any gyro rate except a power-down code
	wire ipm_mode_t gyr_mode =
		(gyr_run_mode != PM_DOWN && ctrl4_r[GYRO_SLEEP_BIT]) ?
		PM_SLEEP : gyr_run_mode;
	// R5: each sensor runs on its own
	wire logic acc_run = running && acc_mode != PM_DOWN;
	wire logic gyr_run = running && (gyr_mode == PM_LOW ||
		gyr_mode == PM_HIGH);

	// ------------------------------------------------------------
	// Sample timing
	// ------------------------------------------------------------
	logic acc_tick;
	logic gyr_tick;

	// R4: independent codes, shared timebase
	// R7: ticks nest when both run
	ipm_rate_gen u_rate (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.acc_code_i(acc_code),
		.gyr_code_i(gyr_code),
		.acc_en_i(acc_run),
		.gyr_en_i(gyr_run),
		.acc_tick_o(acc_tick),
		.gyr_tick_o(gyr_tick)
	);

	// ------------------------------------------------------------
	// Output data and ready flags
	// ------------------------------------------------------------
	// R16: data held while powered down
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			acc_z_r <= '0;
		end else if (acc_tick) begin
			acc_z_r <= accel_z_sample_i;
		end
	end

	// R15: Z high read clears ready
	// A new sample in the clearing cycle wins, so none is lost.
	// R14: flag returns on next sample
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			acc_drdy_r <= 1'b0;
			gyr_drdy_r <= 1'b0;
		end else begin
			acc_drdy_r <= acc_tick | (acc_drdy_r & ~rd_z_high);
			gyr_drdy_r <= gyr_tick | (gyr_drdy_r & ~rd_status);
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		case (reg_req_i.addr)
			ADDR_ACCEL_RATE_CTRL: rd_mux = acc_rate_r;
			ADDR_GYRO_RATE_CTRL: rd_mux = gyr_rate_r;
			ADDR_CONTROL_FOUR_REG: rd_mux = ctrl4_r;
			ADDR_MODE_CTRL_C: rd_mux = ctrl6_r;
			ADDR_GYRO_MODE_CTRL: rd_mux = ctrl7_r;
			ADDR_DATA_READY_STATUS: begin
				rd_mux[ACCEL_DRDY_BIT] = acc_drdy_r;
				rd_mux[GYRO_DRDY_BIT] = gyr_drdy_r;
			end
			ADDR_ACCEL_Z_OUT_LOW: rd_mux = acc_z_r[7:0];
			ADDR_ACCEL_Z_OUT_HIGH: rd_mux = acc_z_r[15:8];
			default: rd_mux = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o <= 8'h00;
			boot_busy_o <= 1'b1;
			trim_load_o <= 1'b0;
			accel_mode_o <= PM_DOWN;
			gyro_mode_o <= PM_DOWN;
			accel_on_o <= 1'b0;
			gyro_drive_on_o <= 1'b0;
			accel_sample_o <= 1'b0;
			gyro_sample_o <= 1'b0;
		end else begin
			if (rd_ok) reg_rdata_o <= rd_mux;
			boot_busy_o <= !running;
			// R1: trim load during boot
			trim_load_o <= !running;
			// R2: modes read power-down until boot ends
			accel_mode_o <= running ? acc_mode : PM_DOWN;
			gyro_mode_o <= running ? gyr_mode : PM_DOWN;
			// R18: high-performance keeps chain on
			// Low-power chain only wakes for a sample to save current.
			accel_on_o <= acc_run && (acc_mode == PM_HIGH || acc_tick);
			gyro_drive_on_o <= running && gyr_mode != PM_DOWN;
			accel_sample_o <= acc_tick;
			gyro_sample_o <= gyr_tick;
		end
	end

	// R18: ready flags drive interrupt lines
	assign accel_drdy_o = acc_drdy_r;
	assign gyro_drdy_o = gyr_drdy_r;

endmodule : ipm_power_ctrl
`default_nettype wire

// ---- dv/ipm_power_ctrl_monitor.sv ----
// Port checker for the power-mode control block
`timescale 1ns/1ps
`default_nettype none
module ipm_power_ctrl_monitor
	import ipm_pkg::*;
#(
	parameter int unsigned BOOT_CYCLES = BOOT_CYC
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire ipm_reg_req_t reg_req_i,
	input wire logic boot_busy_o,
	input wire ipm_mode_t accel_mode_o,
	input wire ipm_mode_t gyro_mode_o,
	input wire logic accel_on_o,
	input wire logic gyro_drive_on_o,
	input wire logic accel_sample_o,
	input wire logic gyro_sample_o,
	input wire logic accel_drdy_o
);
	// ----
	// Helpers
	// ----
	int unsigned busy_r;
	int unsigned gap_r;
	logic seen_r;
	wire logic any_w = accel_sample_o | gyro_sample_o;
	wire logic acc_w = accel_mode_o inside {PM_LOW, PM_HIGH};
	wire logic gyr_w = gyro_mode_o inside {PM_LOW, PM_HIGH};
	// Grid forgotten when both idle, though the timebase never pauses
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			busy_r <= 0;
			gap_r <= 0;
			seen_r <= 1'b0;
		end else begin
			busy_r <= busy_r + 32'(boot_busy_o);
			gap_r <= any_w ? 1 : gap_r + 1;
			seen_r <= (seen_r | any_w) & (acc_w | gyr_w);
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);
	sequence s_rd_z;
		reg_req_i.rd && !boot_busy_o &&
			reg_req_i.addr == ADDR_ACCEL_Z_OUT_HIGH;
	endsequence
	AST_BOOT_LEN: assert property (
		busy_r <= BOOT_CYCLES + 2) else $error("boot too long");
	AST_BOOT_DOWN: assert property (
		$fell(boot_busy_o) |-> accel_mode_o == PM_DOWN &&
		gyro_mode_o == PM_DOWN) else $error("not down after boot");
	AST_RD_CLR: assert property (
		s_rd_z |=> !accel_drdy_o || accel_sample_o)
		else $error("ready not cleared");
	AST_DRDY_SET: assert property (
		accel_sample_o |-> accel_drdy_o) else $error("ready not set");
	AST_PD_HOLD: assert property (
		accel_mode_o == PM_DOWN && $past(accel_mode_o) == PM_DOWN
		|-> !accel_sample_o) else $error("sample while down");
	AST_SLEEP: assert property (
		gyro_mode_o == PM_SLEEP && $past(gyro_mode_o) == PM_SLEEP
		|-> !gyro_sample_o && gyro_drive_on_o) else $error("bad sleep");
	AST_SYNC: assert property (
		any_w && seen_r && acc_w && gyr_w |-> gap_r % BASE_CYC == 0)
		else $error("ticks off grid");
	AST_HP_ON: assert property (
		accel_mode_o == PM_HIGH && $past(accel_mode_o) == PM_HIGH
		|-> accel_on_o) else $error("accel off in high mode");
endmodule : ipm_power_ctrl_monitor
bind ipm_power_ctrl ipm_power_ctrl_monitor
	#(.BOOT_CYCLES(BOOT_CYCLES)) u_mon (
	.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_req_i(reg_req_i),
	.boot_busy_o(boot_busy_o), .accel_mode_o(accel_mode_o),
	.gyro_mode_o(gyro_mode_o), .accel_on_o(accel_on_o),
	.gyro_drive_on_o(gyro_drive_on_o), .accel_sample_o(accel_sample_o),
	.gyro_sample_o(gyro_sample_o), .accel_drdy_o(accel_drdy_o)
);
`default_nettype wire

// ---- dv/ipm_host_model.sv ----
// Host model driving the register request port
`timescale 1ns/1ps
`default_nettype none
module ipm_host_model
	import ipm_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic [7:0] rdata_i,
	input wire logic drdy_i,
	output ipm_reg_req_t req_o
);
	initial req_o = '{1'b0, 1'b0, 8'h00, 8'h00};
	// Idle bus shows inverted address and data, not stale ones
	task automatic put(input logic w, logic [7:0] a, logic [7:0] v);
		@(posedge clk_sys_i);
		#1 req_o = '{w, !w, a, v};
		@(posedge clk_sys_i);
		#1 req_o = '{1'b0, 1'b0, ~a, ~v};
	endtask : put
	task automatic wr(input logic [7:0] a, logic [7:0] v);
		put(1'b1, a, v);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		put(1'b0, a, 8'h00);
		v = rdata_i;
	endtask : rd
	task automatic hp_start(input logic [7:0] rate, output logic ok);
		logic [7:0] v;
		int n;
		wr(ADDR_MODE_CTRL_C, 8'h10);
		wr(ADDR_ACCEL_RATE_CTRL, 8'h50);
		rd(ADDR_ACCEL_Z_OUT_HIGH, v);
		n = 0;
		while (drdy_i !== 1'b1 && n < 100000) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		ok = drdy_i;
		wr(ADDR_MODE_CTRL_C, 8'h00);
		wr(ADDR_ACCEL_RATE_CTRL, rate);
	endtask : hp_start
endmodule : ipm_host_model
`default_nettype wire

// ---- dv/ipm_power_ctrl_tb.sv ----
// Self-checking bench for the power-mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin total_checks++; if ((g) !== (e)) begin \
	fail_count++; $display("BAD %s exp %h got %h", s, e, g); end end
module ipm_power_ctrl_tb
	import ipm_pkg::*;
;
	localparam int unsigned BOOT_N = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	ipm_reg_req_t req;
	logic [15:0] z = 16'h5a3c;
	logic [7:0] rdat, d;
	logic busy, acc_on, gyr_on, a_smp, g_smp, a_rdy, ok, trim, g_rdy;
	ipm_mode_t a_mode, g_mode;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int n;
	ipm_power_ctrl #(.BOOT_CYCLES(BOOT_N)) dut (
		.clk_sys_i(clk), .reset_i(rst), .reg_req_i(req),
		.accel_z_sample_i(z), .reg_rdata_o(rdat), .boot_busy_o(busy),
		.trim_load_o(trim), .accel_mode_o(a_mode), .gyro_mode_o(g_mode),
		.accel_on_o(acc_on), .gyro_drive_on_o(gyr_on),
		.accel_sample_o(a_smp), .gyro_sample_o(g_smp),
		.accel_drdy_o(a_rdy), .gyro_drdy_o(g_rdy)
	);
	ipm_host_model host (
		.clk_sys_i(clk), .rdata_i(rdat), .drdy_i(a_rdy), .req_o(req)
	);
	initial begin
		forever #25 clk = ~clk;
	end
	// Ceiling covers the slowest ready wait
	always @(posedge clk) begin
		cyc++;
		if (cyc == 130000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	function automatic ipm_mode_t em(input int c, bit hp, bit acc);
		if (c >= 1 && c <= 5) return hp ? PM_LOW : PM_HIGH;
		if (c >= 6 && c <= 10) return PM_HIGH;
		if (acc && c == 11 && hp) return PM_LOW;
		return PM_DOWN;
	endfunction : em
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	task automatic wait_acc();
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (a_smp !== 1'b1 && n < 3200);
	endtask : wait_acc
	initial begin
		repeat (8) @(posedge clk);
		`CHK("busy", 1'b1, busy);
		`CHK("trim rst", 1'b0, trim);
		#1 rst = 1'b0;
		host.wr(ADDR_ACCEL_RATE_CTRL, 8'ha0);
		`CHK("trim", 1'b1, trim);
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK("boot", 1'b1, n <= BOOT_N);
		`CHK("trim end", 1'b0, trim);
		`CHK("acc down", PM_DOWN, a_mode);
		`CHK("gyr down", PM_DOWN, g_mode);
		host.rd(ADDR_ACCEL_RATE_CTRL, d);
		`CHK("early wr", 8'h00, d);
		host.wr(8'h20, 8'hff);
		host.rd(8'h20, d);
		`CHK("unmapped", 8'h00, d);
		$display("test boot done");
		for (int s = 0; s < 2; s++) begin
			for (int h = 0; h < 2; h++) begin
				for (int c = 0; c < 16; c++) begin
					host.wr(s ? ADDR_GYRO_MODE_CTRL : ADDR_MODE_CTRL_C,
						8'(h) << (s ? GYRO_HP_DIS_BIT : ACCEL_HP_DIS_BIT));
					host.wr(s ? ADDR_GYRO_RATE_CTRL : ADDR_ACCEL_RATE_CTRL,
						8'(c) << RATE_SEL_LSB);
					host.rd(s ? ADDR_GYRO_RATE_CTRL : ADDR_ACCEL_RATE_CTRL, d);
					`CHK("rate rd", 8'(c) << RATE_SEL_LSB, d);
					settle();
					`CHK("mode", em(c, h, !s), s ? g_mode : a_mode);
				end
			end
		end
		$display("test mode table done");
		host.wr(ADDR_GYRO_RATE_CTRL, 8'ha0);
		host.wr(ADDR_CONTROL_FOUR_REG, 8'h40);
		settle();
		`CHK("sleep", PM_SLEEP, g_mode);
		`CHK("drive", 1'b1, gyr_on);
		host.wr(ADDR_GYRO_RATE_CTRL, 8'h00);
		settle();
		`CHK("pd wins", PM_DOWN, g_mode);
		host.wr(ADDR_CONTROL_FOUR_REG, 8'h00);
		$display("test sleep done");
		host.wr(ADDR_GYRO_RATE_CTRL, 8'ha0);
		host.wr(ADDR_MODE_CTRL_C, 8'h00);
		host.wr(ADDR_ACCEL_RATE_CTRL, 8'ha0);
		wait_acc();
		wait_acc();
		`CHK("period", BASE_CYC, n);
		`CHK("sync", 1'b1, g_smp);
		`CHK("g ready", 1'b1, g_rdy);
		`CHK("ready", 1'b1, a_rdy);
		`CHK("hp on", 1'b1, acc_on);
		host.rd(ADDR_DATA_READY_STATUS, d);
		`CHK("status", 2'b11, d[1:0]);
		`CHK("g clear", 1'b0, g_rdy);
		host.rd(ADDR_ACCEL_Z_OUT_LOW, d);
		`CHK("z low", 8'h3c, d);
		host.rd(ADDR_ACCEL_Z_OUT_HIGH, d);
		`CHK("z high", 8'h5a, d);
		`CHK("cleared", 1'b0, a_rdy);
		$display("test samples done");
		host.wr(ADDR_ACCEL_RATE_CTRL, 8'h00);
		z = 16'hc3a5;
		repeat (3100) @(posedge clk);
		#1;
		host.rd(ADDR_ACCEL_Z_OUT_HIGH, d);
		`CHK("z held", 8'h5a, d);
		`CHK("no ready", 1'b0, a_rdy);
		$display("test hold done");
		host.hp_start(8'ha0, ok);
		`CHK("seq ready", 1'b1, ok);
		settle();
		`CHK("seq mode", PM_HIGH, a_mode);
		$display("test sequence done");
		print_verdict();
	end
endmodule : ipm_power_ctrl_tb
`default_nettype wire
